// *** logic/pdto_pkg.sv ***
package pdto_pkg;
   // system clock and derived timing
   localparam int SYS_CLK_HZ = 25_000_000;
   localparam int PWM_RATE_HZ = 32_500;
   localparam int PWM_STEPS = 64;
   // counter advance period; rounded down so the rate never falls short
   localparam int PREDIV_CYCLES = SYS_CLK_HZ / (PWM_RATE_HZ * PWM_STEPS);
   localparam int TONE_HZ = 62_500;
   localparam int TONE_HALF_CYCLES = SYS_CLK_HZ / (2 * TONE_HZ);
   localparam logic [3:0] PREDIV_LAST = 4'(PREDIV_CYCLES - 1);
   localparam logic [7:0] TONE_LAST = 8'(TONE_HALF_CYCLES - 1);

   // register indices; byte address is four times the index
   localparam logic [7:0] REG_CH0_IDX = 8'he0;
   localparam logic [7:0] REG_CH1_IDX = 8'he1;
   localparam logic [7:0] REG_CH2_IDX = 8'he2;
   localparam logic [7:0] REG_CH3_IDX = 8'he3;
   localparam logic [7:0] REG_STATUS_IDX = 8'hf0;
   localparam int NUM_CH = 4;

   // field layout of a channel register
   localparam int LEVEL_MSB = 5;
   localparam int ENABLE_BIT = 6;
   localparam int UPPER_BIT = 7;
   localparam logic [7:0] CH_REG_RST = 8'h00;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
endpackage

// *** logic/pdto_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdto_channel
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [5:0] i_count,
   input wire logic [5:0] i_level,
   input wire logic i_enable,
   output logic o_pin_oe
);
   import pdto_pkg::*;

   // open drain: pull the pin low unless the channel wants it high
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         o_pin_oe <= 1'b1;
      else
         o_pin_oe <= !(i_enable && (i_count >= i_level));
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   property p_disabled_low;
      !i_enable |=> o_pin_oe;
   endproperty
   a_disabled_low: assert property (p_disabled_low)
      else $error("disabled channel not held low");

   property p_zero_level_high;
      i_enable && i_level == 6'h00 |=> !o_pin_oe;
   endproperty
   a_zero_level_high: assert property (p_zero_level_high)
      else $error("zero level not held high");

   property p_full_level_low;
      i_enable && i_level == 6'h3f && i_count != 6'h3f |=> o_pin_oe;
   endproperty
   a_full_level_low: assert property (p_full_level_low)
      else $error("full level high outside last step");

   property p_compare;
      i_enable |=> o_pin_oe == ($past(i_count) < $past(i_level));
   endproperty
   a_compare: assert property (p_compare)
      else $error("channel compare mismatch");
endmodule
`default_nettype wire

// *** logic/pdto_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdto_top
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic [pdto_pkg::NUM_CH-1:0] i_pwm_outputs,
   output logic [pdto_pkg::NUM_CH-1:0] o_pwm_outputs,
   output logic [pdto_pkg::NUM_CH-1:0] o_pwm_outputs_oe,
   input wire logic i_tone_pin,
   output logic o_tone_pin,
   output logic o_tone_pin_oe,
   input wire logic i_ext_irq_pin,
   output logic o_ext_irq,
   output logic o_comparator_ref_shift
);
   import pdto_pkg::*;

   logic [7:0] ch_reg [NUM_CH];
   logic [7:0] next_ch_reg [NUM_CH];
   logic [3:0] prediv;
   logic count_tick;
   logic [5:0] pwm_count;
   logic [7:0] tone_div;
   logic tone_square;
   logic dp_write;
   logic [7:0] dp_idx;
   logic ap_take;
   logic [7:0] ap_idx;
   logic ap_mapped;
   logic [31:0] next_rdata;

   // address phase decode; only word transfers reach the registers
   assign ap_take = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ)
      && (i_hsize == HSIZE_WORD);
   assign ap_idx = i_haddr[9:2];
   assign ap_mapped = (i_haddr[31:10] == 22'h000000)
      && (i_haddr[1:0] == 2'h0);

   // remember a write for its data phase
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         dp_write <= 1'b0;
         dp_idx <= 8'h00;
      end
      else
      begin
         dp_write <= ap_take && i_hwrite && ap_mapped;
         dp_idx <= ap_idx;
      end
   end

   // next register contents; reads see a write landing in the same edge
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         next_ch_reg[i] = ch_reg[i];
         if (dp_write && dp_idx == REG_CH0_IDX + 8'(i))
            next_ch_reg[i] = i_hwdata[7:0];
      end
   end

   // registers come up cleared; software still writes all before use
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < NUM_CH; i++)
            ch_reg[i] <= CH_REG_RST;
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
            ch_reg[i] <= next_ch_reg[i];
      end
   end

   // read mux; irq enable reads back as zero
   always_comb
   begin
      next_rdata = 32'h00000000;
      if (ap_mapped)
      begin
         case (ap_idx)
            REG_CH0_IDX: next_rdata[7:0] = next_ch_reg[0];
            REG_CH1_IDX: next_rdata[7:0] = next_ch_reg[1];
            REG_CH2_IDX:
               next_rdata[6:0] = next_ch_reg[2][6:0];
            REG_CH3_IDX: next_rdata[7:0] = next_ch_reg[3];
            REG_STATUS_IDX:
               next_rdata[11:0] = {pwm_count, i_ext_irq_pin, i_tone_pin,
                  i_pwm_outputs};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // bus answers: zero wait states, always okay
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= HRESP_OKAY;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= HRESP_OKAY;
         if (ap_take && !i_hwrite)
            o_hrdata <= next_rdata;
         else
            o_hrdata <= 32'h00000000;
      end
   end

   // pre-divider: one counter step every few system clocks
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         prediv <= 4'h0;
      else if (prediv == PREDIV_LAST)
         prediv <= 4'h0;
      else
         prediv <= prediv + 4'h1;
   end

   assign count_tick = (prediv == PREDIV_LAST);

   // shared time base; 64 steps make one pwm period
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         pwm_count <= 6'h00;
      else if (count_tick)
         pwm_count <= pwm_count + 6'h01;
   end

   // one comparator per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : gen_ch
         pdto_channel u_ch
         (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_count(pwm_count),
            .i_level(ch_reg[g][LEVEL_MSB:0]),
            .i_enable(ch_reg[g][ENABLE_BIT]),
            .o_pin_oe(o_pwm_outputs_oe[g])
         );
      end
   endgenerate

   // tone: toggle every half period for an even square wave
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         tone_div <= 8'h00;
         tone_square <= 1'b0;
      end
      else if (tone_div == TONE_LAST)
      begin
         tone_div <= 8'h00;
         tone_square <= !tone_square;
      end
      else
         tone_div <= tone_div + 8'h01;
   end

   // open-drain pins only ever drive low
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_pwm_outputs <= '0;
         o_tone_pin <= 1'b0;
         o_tone_pin_oe <= 1'b1;
      end
      else
      begin
         o_pwm_outputs <= '0;
         o_tone_pin <= 1'b0;
         if (ch_reg[0][UPPER_BIT])
            o_tone_pin_oe <= !tone_square;
         else
            o_tone_pin_oe <= !ch_reg[1][UPPER_BIT];
      end
   end

   // interrupt gate and reference shift; level passed, edge seen later
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         o_ext_irq <= 1'b0;
         o_comparator_ref_shift <= 1'b0;
      end
      else
      begin
         o_ext_irq <= i_ext_irq_pin && ch_reg[2][UPPER_BIT];
         o_comparator_ref_shift <= ch_reg[3][UPPER_BIT];
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_wr_ch0;
      ap_take && i_hwrite && ap_mapped && ap_idx == REG_CH0_IDX ##1 1'b1;
   endsequence

   property p_write_ch0;
      s_wr_ch0 |=> ch_reg[0] == $past(i_hwdata[7:0]);
   endproperty
   a_write_ch0: assert property (p_write_ch0)
      else $error("channel zero write lost");

   property p_count_step;
      count_tick |=> pwm_count == $past(pwm_count) + 6'h01;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter did not advance");

   property p_tick_gap;
      count_tick |=> !count_tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("pre-divider too fast");

   property p_tone_toggle;
      tone_div == TONE_LAST |=> tone_square != $past(tone_square);
   endproperty
   a_tone_toggle: assert property (p_tone_toggle)
      else $error("tone did not toggle");

   property p_tone_route;
      ch_reg[0][UPPER_BIT] |=> o_tone_pin_oe == !$past(tone_square);
   endproperty
   a_tone_route: assert property (p_tone_route)
      else $error("tone not on pin");

   property p_pin_data;
      !ch_reg[0][UPPER_BIT] |=> o_tone_pin_oe == !$past(ch_reg[1][7]);
   endproperty
   a_pin_data: assert property (p_pin_data)
      else $error("tone pin not following data bit");

   property p_irq_gate;
      !ch_reg[2][UPPER_BIT] |=> !o_ext_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt passed while disabled");

   property p_irq_hidden;
      ap_take && !i_hwrite && ap_mapped && ap_idx == REG_CH2_IDX
         |=> !o_hrdata[UPPER_BIT];
   endproperty
   a_irq_hidden: assert property (p_irq_hidden)
      else $error("irq enable readable");

   property p_ref_shift;
      ##1 o_comparator_ref_shift == $past(ch_reg[3][UPPER_BIT]);
   endproperty
   a_ref_shift: assert property (p_ref_shift)
      else $error("reference shift mismatch");
endmodule
`default_nettype wire

// *** verif/pdto_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdto_pin_model
(
   input wire logic [3:0] i_pwm_drive,
   input wire logic [3:0] i_pwm_oe,
   input wire logic i_tone_drive,
   input wire logic i_tone_oe,
   output logic [3:0] o_pwm_level,
   output logic o_tone_level
);
   // open-drain lines with pull-ups into the filters: released reads high
   assign o_pwm_level = (i_pwm_oe & i_pwm_drive) | ~i_pwm_oe;
   assign o_tone_level = i_tone_oe ? i_tone_drive : 1'b1;
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pdto_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic irq_pin = 1'b0;
   logic hready, hresp, tone_d, tone_oe, tone_lvl, ext_irq, ref_sh;
   logic [31:0] hrdata, rd;
   logic [3:0] pwm_d, pwm_oe, pwm_lvl;
   logic [7:0] wv [4] = '{8'h40, 8'hff, 8'he0, 8'hbf};
   logic [7:0] rv [4] = '{8'h40, 8'hff, 8'h60, 8'hbf};
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int hi [5];

   initial
   begin
      forever #20 clk = ~clk;
   end

   pdto_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(HSIZE_WORD), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
      .i_pwm_outputs(pwm_lvl), .o_pwm_outputs(pwm_d),
      .o_pwm_outputs_oe(pwm_oe), .i_tone_pin(tone_lvl),
      .o_tone_pin(tone_d), .o_tone_pin_oe(tone_oe),
      .i_ext_irq_pin(irq_pin), .o_ext_irq(ext_irq),
      .o_comparator_ref_shift(ref_sh));

   pdto_pin_model pins (.i_pwm_drive(pwm_d), .i_pwm_oe(pwm_oe),
      .i_tone_drive(tone_d), .i_tone_oe(tone_oe),
      .o_pwm_level(pwm_lvl), .o_tone_level(tone_lvl));

   task automatic print_verdict();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard: the whole sequence needs under 3000 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask

   // counts high cycles of each pin after letting the pins settle
   task automatic count(input int n);
      repeat (2) @(posedge clk);
      for (int k = 0; k < 5; k++) hi[k] = 0;
      repeat (n)
      begin
         @(posedge clk);
         for (int k = 0; k < 4; k++) hi[k] += int'(pwm_lvl[k]);
         hi[4] += int'(tone_lvl);
      end
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, REG_CH0_IDX, 32'h0);
      chk(rd, 32'h0);
      count(4);
      chk({27'h0, pwm_lvl, tone_lvl}, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, REG_CH0_IDX + 8'(k), {24'h0, wv[k]});
      end
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b0, REG_CH0_IDX + 8'(k), 32'h0);
         chk(rd, {24'h0, rv[k]});
      end
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, REG_STATUS_IDX, 32'h0);
      chk({30'h0, rd[5:4]}, 32'h1);
      chk({31'h0, ref_sh}, 32'h1);
      $display("test registers done");
      irq_pin <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, ext_irq}, 32'h1);
      bus(1'b1, REG_CH2_IDX, 32'h60);
      // clear the reference shift too; channel three stays disabled
      bus(1'b1, REG_CH3_IDX, 32'h3f);
      repeat (2) @(posedge clk);
      chk({31'h0, ext_irq}, 32'h0);
      chk({31'h0, ref_sh}, 32'h0);
      irq_pin <= 1'b0;
      $display("test interrupt gate done");
      count(PWM_STEPS * PREDIV_CYCLES);
      chk(32'(hi[0]), 32'(PWM_STEPS * PREDIV_CYCLES));
      chk(32'(hi[1]), 32'(PREDIV_CYCLES));
      chk(32'(hi[2]), 32'(32 * PREDIV_CYCLES));
      chk(32'(hi[3]), 32'h0);
      chk(32'(hi[4]), 32'(PWM_STEPS * PREDIV_CYCLES));
      $display("test levels done");
      bus(1'b1, REG_CH1_IDX, 32'h3f);
      bus(1'b1, REG_CH0_IDX, 32'hc0);
      count(4 * TONE_HALF_CYCLES);
      chk(32'(hi[4]), 32'(2 * TONE_HALF_CYCLES));
      chk(32'(hi[1]), 32'h0);
      bus(1'b1, REG_CH0_IDX, 32'h0);
      count(4 * TONE_HALF_CYCLES);
      chk(32'(hi[4]), 32'h0);
      chk(32'(hi[0]), 32'h0);
      $display("test tone done");
      print_verdict();
   end
endmodule
`default_nettype wire
